/* core/ieep_bus_if.sv */
/*
 * Two-wire bus carrier joining the EEPROM slave end and the master end.
 * Assumes pull-ups: a line reads low whenever any party enables its driver.
 */
`timescale 1ns/1ps
interface ieep_bus_if;
	// Master drives the clock low when enabled.
	logic scl_oe;
	// Data drivers of both ends; enable high means the end pulls low.
	logic sda_m_oe;
	logic sda_s_oe;
	// Resolved wire levels.
	logic scl;
	logic sda;
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	// Device end.
	modport slave(input scl, input sda, output sda_s_oe);
	// Master end.
	modport master(input scl, input sda, output scl_oe, output sda_m_oe);
endinterface

/* core/ieep_master.sv */
/*
 * Bus master end: writes up to two bytes or reads a stream from the EEPROM.
 * Assumes one request at a time on a user port and a single slave clock source.
 */
`timescale 1ns/1ps
module ieep_master (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Request port.
	input wire logic req_in,
	input wire logic rd_in,
	input wire logic set_ptr_in,
	input wire logic [2:0] chip_in,
	input wire logic [6:0] addr_in,
	input wire logic [1:0] count_in,
	input wire logic [7:0] wdata0_in,
	input wire logic [7:0] wdata1_in,
	input wire logic [7:0] rd_len_in,
	// Answer port.
	output logic busy_out,
	output logic rdata_vld_out,
	output logic [7:0] rdata_out,
	output logic nack_out,
	// Bus.
	ieep_bus_if.master bus
);
	// Phases of a transfer.
	typedef enum logic [2:0] {IEEPM_IDLE, IEEPM_START, IEEPM_BYTE, IEEPM_STOP,
		IEEPM_DONE} ieepm_state_e;
	ieepm_state_e state_r;
	logic [9:0] div_r;
	logic [1:0] q_r;
	logic [3:0] bit_r;
	logic [7:0] tx_r;
	logic [7:0] rx_r;
	logic [2:0] idx_r;
	logic reading_r;
	logic rd_r;
	logic set_r;
	logic [2:0] chip_r;
	logic [6:0] addr_r;
	logic [1:0] cnt_r;
	logic [7:0] w0_r;
	logic [7:0] w1_r;
	logic [7:0] left_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic [2:0] sda_sync_r;

	// Quarter-period tick of the generated clock.
	wire tick = (div_r == ieep_pkg::SCL_HALF);
	wire sda_in = sda_sync_r[2];
	wire [7:0] adr_w = {ieep_pkg::DEV_TYPE, chip_r, 1'b0};
	wire [7:0] adr_r = {ieep_pkg::DEV_TYPE, chip_r, 1'b1};

	assign bus.scl_oe = scl_oe_r;
	assign bus.sda_m_oe = sda_oe_r;
	assign busy_out = (state_r != IEEPM_IDLE);

	// Byte to send for sequence step idx: address, word address, data, read address.
	function automatic logic [7:0] step_byte(input logic [2:0] idx);
		case (idx)
			3'h0: step_byte = adr_w;
			3'h1: step_byte = {1'b0, addr_r};
			3'h2: step_byte = w0_r;
			3'h3: step_byte = w1_r;
			default: step_byte = adr_r;
		endcase
	endfunction

	// Divider, sampler and transfer sequencer.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= IEEPM_IDLE;
			div_r <= 10'h000;
			q_r <= 2'h0;
			bit_r <= 4'h0;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			idx_r <= 3'h0;
			reading_r <= 1'b0;
			rd_r <= 1'b0;
			set_r <= 1'b0;
			chip_r <= 3'h0;
			addr_r <= 7'h00;
			cnt_r <= 2'h0;
			w0_r <= 8'h00;
			w1_r <= 8'h00;
			left_r <= 8'h00;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_sync_r <= 3'h7;
			rdata_vld_out <= 1'b0;
			rdata_out <= 8'h00;
			nack_out <= 1'b0;
		end else begin
			sda_sync_r <= {sda_sync_r[1:0], bus.sda};
			rdata_vld_out <= 1'b0;
			div_r <= tick ? 10'h000 : div_r + 10'h001;
			case (state_r)
				IEEPM_IDLE: begin
					if (req_in) begin
						rd_r <= rd_in;
						set_r <= set_ptr_in;
						chip_r <= chip_in;
						addr_r <= addr_in;
						// Never more than two data bytes in one write.
						cnt_r <= (count_in > 2'h2) ? 2'h2 : count_in;
						w0_r <= wdata0_in;
						w1_r <= wdata1_in;
						left_r <= rd_len_in;
						nack_out <= 1'b0;
						idx_r <= (rd_in && !set_ptr_in) ? 3'h4 : 3'h0;
						q_r <= 2'h0;
						state_r <= IEEPM_START;
					end
				end
				IEEPM_START: begin
					// Release data, then clock, then pull data low while the clock is high.
					// A repeated start thus keeps the clock low for two quarters, a full low phase.
					if (tick) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: sda_oe_r <= 1'b0;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b1;
							default: begin
								scl_oe_r <= 1'b1;
								tx_r <= step_byte(idx_r);
								reading_r <= 1'b0;
								bit_r <= 4'h0;
								q_r <= 2'h0;
								state_r <= IEEPM_BYTE;
							end
						endcase
					end
				end
				IEEPM_BYTE: begin
					if (tick) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: begin
								// Clock low: set data for this bit or release it.
								if (bit_r == 4'h8) begin
									sda_oe_r <= reading_r && left_r != 8'h01;
								end else begin
									sda_oe_r <= !reading_r && !tx_r[7];
								end
							end
							2'h1: scl_oe_r <= 1'b0;
							2'h2: begin
								// Clock high: sample the line.
								if (bit_r == 4'h8 && !reading_r && sda_in) begin
									nack_out <= 1'b1;
								end
								if (bit_r != 4'h8) begin
									rx_r <= {rx_r[6:0], sda_in};
									tx_r <= {tx_r[6:0], 1'b0};
								end
							end
							default: begin
								scl_oe_r <= 1'b1;
								q_r <= 2'h0;
								bit_r <= bit_r + 4'h1;
								if (bit_r == 4'h8) begin
									// The acknowledge is held past the clock fall: a release on
									// the fall itself would look like a STOP to the slave.
									bit_r <= 4'h0;
									if (reading_r) begin
										rdata_out <= rx_r;
										rdata_vld_out <= 1'b1;
										left_r <= left_r - 8'h01;
										if (left_r == 8'h01) begin
											state_r <= IEEPM_STOP;
										end
									end else if (nack_out) begin
										state_r <= IEEPM_STOP;
									end else if (idx_r == 3'h4) begin
										reading_r <= 1'b1;
									end else if (idx_r == 3'h1 && rd_r) begin
										idx_r <= 3'h4;
										q_r <= 2'h0;
										state_r <= IEEPM_START;
									end else if (idx_r == 3'h1 && cnt_r == 2'h0) begin
										state_r <= IEEPM_STOP;
									end else if (idx_r == 3'h1 || (idx_r == 3'h2 && cnt_r == 2'h2)) begin
										idx_r <= idx_r + 3'h1;
										tx_r <= step_byte(idx_r + 3'h1);
									end else if (idx_r == 3'h0) begin
										idx_r <= 3'h1;
										tx_r <= step_byte(3'h1);
									end else begin
										state_r <= IEEPM_STOP;
									end
								end
							end
						endcase
					end
				end
				IEEPM_STOP: begin
					// Data low, clock high, then data high while clock high.
					if (tick) begin
						q_r <= q_r + 2'h1;
						case (q_r)
							2'h0: sda_oe_r <= 1'b1;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b0;
							default: state_r <= IEEPM_DONE;
						endcase
					end
				end
				IEEPM_DONE: begin
					state_r <= IEEPM_IDLE;
				end
				default: begin
					state_r <= IEEPM_IDLE;
				end
			endcase
		end
	end
endmodule

/* core/ieep_pkg.sv */
/*
 * Shared constants for the serial EEPROM slave and its bus master end.
 * Assumes a single 250 MHz system clock in each end and an open-drain bus.
 */
package ieep_pkg;
	// System clock period in picoseconds.
	localparam int unsigned CLK_PS = 4000;
	// Noise filter time constant, typical, in nanoseconds.
	localparam int unsigned FILT_NS = 500;
	// Filter length in clock cycles, rounded down.
	localparam int unsigned FILT_CYC = (FILT_NS * 1000) / CLK_PS;
	// Erase/write interval per byte, typical, in milliseconds.
	localparam int unsigned EW_MS = 30;
	// Erase/write interval per byte in clock cycles.
	localparam int unsigned EW_CYC = (EW_MS * 1000000) / (CLK_PS / 1000);
	// Memory depth and address width.
	localparam int unsigned MEM_WORDS = 128;
	localparam int unsigned ADDR_W = 7;
	// Data bytes accepted in one write transfer.
	localparam logic [1:0] MAX_WR_BYTES = 2'h2;
	// Fixed upper slave-address bits for this device type.
	localparam logic [3:0] DEV_TYPE = 4'hA;
	// Link clock divider: quarter period less one, in system cycles, for the master end.
	localparam logic [9:0] SCL_HALF = 10'h271;
endpackage

/* core/ieep_slave.sv */
/*
 * Slave protocol engine of a 128 x 8 serial EEPROM on the two-wire bus.
 * Assumes the bus interface resolves open-drain levels and that the
 * erase/write timer output of the external network is not modelled:
 * the interval is counted from the system clock.
 */
`timescale 1ns/1ps
module ieep_slave #(
	// Erase interval per byte in system cycles; a bench may shorten it to keep runs brief.
	parameter int unsigned EW_CYCLES = ieep_pkg::EW_CYC
) (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Strapped chip-select pins.
	input wire logic chip_select_pin_0_in,
	input wire logic chip_select_pin_1_in,
	input wire logic chip_select_pin_2_in,
	// Status for the user side.
	output logic busy_out,
	output logic [ieep_pkg::ADDR_W-1:0] word_address_value_out,
	// Bus.
	ieep_bus_if.slave bus
);
	// Protocol phases.
	typedef enum logic [2:0] {IEEP_IDLE, IEEP_DEVADR, IEEP_WORDADR, IEEP_WRDATA,
		IEEP_RDDATA, IEEP_IGNORE} ieep_state_e;

	// Three-stage samplers for both pins.
	logic [2:0] scl_sync_r;
	logic [2:0] sda_sync_r;
	// Filtered levels and their stability counters.
	logic scl_f_r;
	logic sda_f_r;
	logic [7:0] scl_cnt_r;
	logic [7:0] sda_cnt_r;
	// Byte engine state.
	ieep_state_e state_r;
	logic [3:0] bit_r;
	logic [7:0] shift_r;
	logic ack_phase_r;
	logic drive_r;
	logic [ieep_pkg::ADDR_W-1:0] ptr_r;
	logic [1:0] wr_cnt_r;
	logic [7:0] buf0_r;
	logic [7:0] buf1_r;
	logic [ieep_pkg::ADDR_W-1:0] wr_addr_r;
	// Erase/write timer.
	logic [31:0] ew_cnt_r;
	logic [1:0] ew_left_r;
	// Memory array.
	logic [7:0] mem_r [0:ieep_pkg::MEM_WORDS-1];

	// A glitch must outlast the filter before it counts.
	wire scl_agree = (scl_sync_r[1] == scl_sync_r[2]);
	wire sda_agree = (sda_sync_r[1] == sda_sync_r[2]);
	wire scl_rise = scl_agree && scl_sync_r[2] && !scl_f_r &&
		(scl_cnt_r == 8'(ieep_pkg::FILT_CYC));
	wire scl_fall = scl_agree && !scl_sync_r[2] && scl_f_r &&
		(scl_cnt_r == 8'(ieep_pkg::FILT_CYC));
	wire sda_rise = sda_agree && sda_sync_r[2] && !sda_f_r &&
		(sda_cnt_r == 8'(ieep_pkg::FILT_CYC));
	wire sda_fall = sda_agree && !sda_sync_r[2] && sda_f_r &&
		(sda_cnt_r == 8'(ieep_pkg::FILT_CYC));
	// Bus conditions: data changes while clock high.
	wire start_det = sda_fall && scl_f_r;
	wire stop_det = sda_rise && scl_f_r;
	wire [2:0] pins = {chip_select_pin_2_in, chip_select_pin_1_in, chip_select_pin_0_in};
	wire busy = (ew_left_r != 2'h0);
	wire [7:0] rx_byte = {shift_r[6:0], sda_f_r};
	// Address match on the full slave address, type bits included.
	// The byte is complete in shift_r when the eighth clock falls.
	wire adr_match = (shift_r[7:4] == ieep_pkg::DEV_TYPE) &&
		(shift_r[3:1] == pins);
	// Master acknowledge slot of a read byte: the slave has released the line.
	// The slave's own address acknowledge keeps drive_r high and so never moves the pointer.
	wire read_ack_slot = (state_r == IEEP_RDDATA) && !drive_r;
	wire [ieep_pkg::ADDR_W-1:0] ptr_inc = ptr_r + 1'b1;

	assign busy_out = busy;
	assign word_address_value_out = ptr_r;
	assign bus.sda_s_oe = drive_r;

	// Input sampling and noise filter on both pins.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			scl_cnt_r <= 8'h00;
			sda_cnt_r <= 8'h00;
		end else begin
			scl_sync_r <= {scl_sync_r[1:0], bus.scl};
			sda_sync_r <= {sda_sync_r[1:0], bus.sda};
			// A level differing from the filtered one must hold before it is taken.
			scl_cnt_r <= (scl_agree && scl_sync_r[2] != scl_f_r &&
				scl_cnt_r != 8'(ieep_pkg::FILT_CYC)) ? scl_cnt_r + 8'h01 : 8'h00;
			sda_cnt_r <= (sda_agree && sda_sync_r[2] != sda_f_r &&
				sda_cnt_r != 8'(ieep_pkg::FILT_CYC)) ? sda_cnt_r + 8'h01 : 8'h00;
			if (scl_rise || scl_fall) begin
				scl_f_r <= scl_sync_r[2];
			end
			if (sda_rise || sda_fall) begin
				sda_f_r <= sda_sync_r[2];
			end
		end
	end

	// Byte engine: bits are taken on clock rise, the line is driven after clock fall.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= IEEP_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			drive_r <= 1'b0;
			ptr_r <= '0;
			wr_cnt_r <= 2'h0;
			buf0_r <= 8'h00;
			buf1_r <= 8'h00;
			wr_addr_r <= '0;
		end else if (start_det) begin
			// Start or repeated start: expect the slave address.
			state_r <= IEEP_DEVADR;
			bit_r <= 4'h0;
			ack_phase_r <= 1'b0;
			drive_r <= 1'b0;
			wr_cnt_r <= 2'h0;
		end else if (stop_det) begin
			state_r <= IEEP_IDLE;
			drive_r <= 1'b0;
		end else if (scl_rise && state_r != IEEP_IDLE && state_r != IEEP_IGNORE) begin
			if (ack_phase_r) begin
				// Ninth pulse: in read mode, sample the master acknowledge.
				if (read_ack_slot && sda_f_r) begin
					state_r <= IEEP_IGNORE;
				end else if (read_ack_slot) begin
					ptr_r <= ptr_inc;
				end
			end else begin
				shift_r <= rx_byte;
				bit_r <= bit_r + 4'h1;
			end
		end else if (scl_fall && state_r != IEEP_IDLE && state_r != IEEP_IGNORE) begin
			if (ack_phase_r) begin
				// End of the ninth pulse: release, or start the next read byte.
				ack_phase_r <= 1'b0;
				bit_r <= 4'h0;
				drive_r <= (state_r == IEEP_RDDATA) && !mem_r[ptr_r][7];
				shift_r <= mem_r[ptr_r];
			end else if (bit_r == 4'h8) begin
				ack_phase_r <= 1'b1;
				drive_r <= 1'b0;
				case (state_r)
					IEEP_DEVADR: begin
						if (adr_match && !busy) begin
							drive_r <= 1'b1;
							state_r <= shift_r[0] ? IEEP_RDDATA : IEEP_WORDADR;
						end else begin
							state_r <= IEEP_IGNORE;
						end
					end
					IEEP_WORDADR: begin
						ptr_r <= shift_r[ieep_pkg::ADDR_W-1:0];
						wr_addr_r <= shift_r[ieep_pkg::ADDR_W-1:0];
						drive_r <= 1'b1;
						state_r <= IEEP_WRDATA;
					end
					IEEP_WRDATA: begin
						if (wr_cnt_r < ieep_pkg::MAX_WR_BYTES) begin
							// First byte goes to the pointer, the second to the next one.
							if (wr_cnt_r == 2'h0) begin
								buf0_r <= shift_r;
							end else begin
								buf1_r <= shift_r;
							end
							wr_cnt_r <= wr_cnt_r + 2'h1;
							drive_r <= 1'b1;
						end else begin
							state_r <= IEEP_IGNORE;
						end
					end
					IEEP_RDDATA: begin
						drive_r <= 1'b0;
					end
					default: begin
						state_r <= IEEP_IGNORE;
					end
				endcase
			end else if (state_r == IEEP_RDDATA) begin
				// The byte shifts left at each rise, so the next bit is always on top.
				drive_r <= !shift_r[7];
			end
		end
	end

	// Erase/write timer: starts at STOP, one interval per byte.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ew_cnt_r <= 32'h0;
			ew_left_r <= 2'h0;
		end else if (stop_det && state_r == IEEP_WRDATA && wr_cnt_r != 2'h0) begin
			ew_left_r <= wr_cnt_r;
			ew_cnt_r <= 32'h0;
		end else if (busy) begin
			if (ew_cnt_r == 32'(EW_CYCLES - 1)) begin
				ew_cnt_r <= 32'h0;
				ew_left_r <= ew_left_r - 2'h1;
			end else begin
				ew_cnt_r <= ew_cnt_r + 32'h1;
			end
		end
	end

	// Array write at the end of each interval; the array has no reset.
	always_ff @(posedge ref_clk_in) begin
		if (busy && ew_cnt_r == 32'(EW_CYCLES - 1)) begin
			if (ew_left_r == 2'h2) begin
				mem_r[wr_addr_r + 7'h01] <= buf1_r;
			end else begin
				mem_r[wr_addr_r] <= buf0_r;
			end
		end
	end
endmodule

/* testbench/ieep_link_assertions.sv */
/* Wire checker for the two-wire EEPROM link.
   Assumes one 250 MHz clock domain and the resolved bus levels. */
`timescale 1ns/1ps
module ieep_link_assertions (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Bus carrier signals.
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda
);
	// Shortest legal clock high and low phases in cycles.
	localparam int HI_MIN = 1000;
	localparam int LO_MIN = 1175;
	logic scl_q_r, sda_q_r, rd_r, data_r, quiet_r; // Line history and frame state.
	logic [3:0] bit_r; // Clock rises seen in the current byte.
	logic [11:0] span_r; // Cycles since the clock last moved, saturating.
	wire scl_rise = scl & ~scl_q_r;
	wire start_c = scl & scl_q_r & sda_q_r & ~sda;
	wire ack_rise = scl_rise & (bit_r == 4'h8);
	wire data_bit = scl_rise & (bit_r < 4'h8);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Data falls while the clock stays high.
	sequence start_s;
		scl && sda ##1 scl && !sda;
	endsequence
	// Data rises while the clock stays high.
	sequence stop_s;
		scl && !sda ##1 scl && sda;
	endsequence
	// Keep the last line levels and time the clock phases.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			span_r <= 12'h0;
		end else begin
			scl_q_r <= scl;
			sda_q_r <= sda;
			span_r <= (scl != scl_q_r) ? 12'h0 : span_r + {11'h0, ~&span_r};
		end
	end
	// Follow bits and direction; a refused address or read nack silences the slave.
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bit_r <= 4'h0;
			rd_r <= 1'b0;
			data_r <= 1'b0;
			quiet_r <= 1'b0;
		end else if (start_c) begin
			bit_r <= 4'h0;
			data_r <= 1'b0;
			quiet_r <= 1'b0;
		end else if (scl_rise) begin
			bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
			data_r <= data_r | (bit_r == 4'h9);
			rd_r <= (bit_r == 4'h7 && !data_r) ? sda : rd_r;
			quiet_r <= quiet_r | (bit_r == 4'h8 && sda && (rd_r || !data_r));
		end
	end
	slave_sda_steady_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("slave data driver moved while clock high");
	addr_slave_off_a: assert property (data_bit && !data_r |-> !sda_s_oe)
		else $error("slave drove the address byte");
	read_master_off_a: assert property (data_bit && data_r && rd_r |-> !sda_m_oe)
		else $error("master drove a read data bit");
	read_ack_free_a: assert property (ack_rise && data_r && rd_r |-> !sda_s_oe)
		else $error("slave drove the master ack slot");
	write_ack_free_a: assert property (ack_rise && !(data_r && rd_r) |-> !sda_m_oe)
		else $error("master drove the slave ack slot");
	nack_release_a: assert property (quiet_r |-> !sda_s_oe)
		else $error("slave drove data after a nack");
	slave_no_cond_a: assert property (start_s or stop_s |-> !sda_s_oe && !$past(sda_s_oe))
		else $error("slave made a start or stop edge");
	clock_high_span_a: assert property ($fell(scl) |-> span_r >= HI_MIN)
		else $error("clock high phase too short");
	clock_low_span_a: assert property ($rose(scl) |-> span_r >= LO_MIN)
		else $error("clock low phase too short");
endmodule

/* testbench/test_i2c_eeprom_slave_128x8.sv */
/* Self-checking bench: master end and EEPROM slave end on one bus carrier.
   Assumes the package bus timing; the erase interval is shortened to keep the run brief. */
`timescale 1ns/1ps
module test_i2c_eeprom_slave_128x8;
	logic ref_clk_in, arst_n_in, req_in, rd_in, set_ptr_in;
	logic [2:0] chip_in, strap; // Strap is the slave's chip-select level set.
	logic [6:0] addr_in;
	logic [ieep_pkg::ADDR_W-1:0] ptr; // Slave pointer as seen from outside.
	logic [1:0] count_in;
	logic [7:0] wdata0_in, wdata1_in, rd_len_in, rdata_out;
	logic m_busy, s_busy, rdata_vld_out, nack_out;
	logic [7:0] exp_q[$]; // Read bytes still expected, oldest first.
	int num_errors, checks_done;
	// Erase interval per byte for this run: two of them outlast one refused address, short to wait.
	localparam int unsigned EW_SIM = 16000;
	int busy_cycles = 0, busy_len = 0; // Current and last erase busy length in cycles.
	ieep_bus_if bus();
	ieep_slave #(.EW_CYCLES(EW_SIM)) u_ieep_slave (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.chip_select_pin_0_in(strap[0]), .chip_select_pin_1_in(strap[1]),
		.chip_select_pin_2_in(strap[2]), .busy_out(s_busy),
		.word_address_value_out(ptr), .bus(bus));
	ieep_master u_ieep_master (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.req_in(req_in), .rd_in(rd_in), .set_ptr_in(set_ptr_in), .chip_in(chip_in),
		.addr_in(addr_in), .count_in(count_in), .wdata0_in(wdata0_in),
		.wdata1_in(wdata1_in), .rd_len_in(rd_len_in), .busy_out(m_busy),
		.rdata_vld_out(rdata_vld_out), .rdata_out(rdata_out), .nack_out(nack_out), .bus(bus));
	ieep_link_assertions u_ieep_link_assertions (.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in), .scl_oe(bus.scl_oe), .sda_m_oe(bus.sda_m_oe),
		.sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
	// Compare one value and count it.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Run one transfer and judge whether it was refused.
	task automatic xfer(input string name, input logic rd, input logic sp, input logic [2:0] chip,
		input logic [6:0] addr, input logic [1:0] cnt, input logic [7:0] len, input logic nack);
		int n;
		@(posedge ref_clk_in);
		req_in <= 1'b1;
		rd_in <= rd;
		set_ptr_in <= sp;
		chip_in <= chip;
		addr_in <= addr;
		count_in <= cnt;
		rd_len_in <= len;
		@(posedge ref_clk_in);
		req_in <= 1'b0;
		// Let the taking edge land before busy is looked at.
		#1;
		for (n = 0; n < 200000 && m_busy !== 1'b0; n++) begin
			@(posedge ref_clk_in);
			#1;
		end
		check({name, " done"}, {7'h0, m_busy}, 8'h0);
		check({name, " nack"}, {7'h0, nack_out}, {7'h0, nack});
		$display("test %s done", name);
	endtask
	// Each read byte is compared with the oldest note.
	always @(posedge ref_clk_in) begin
		if (rdata_vld_out === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("wrong value read byte: expected none, seen %h", rdata_out);
			end else begin
				check("read byte", rdata_out, exp_q.pop_front());
			end
		end
	end
	// Length in cycles of each erase busy period, recorded when it ends.
	always @(posedge ref_clk_in) begin
		if (s_busy === 1'b1) begin
			busy_cycles <= busy_cycles + 1;
		end else if (busy_cycles != 0) begin
			busy_len <= busy_cycles;
			busy_cycles <= 0;
		end
	end
	// Free-running system clock.
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	// Watchdog sized for two erase intervals plus the bus traffic.
	initial begin
		repeat (600000) @(posedge ref_clk_in);
		num_errors++;
		finish_test();
	end
	// Main sequence.
	initial begin
		logic [31:0] r;
		int n;
		num_errors = 0;
		checks_done = 0;
		arst_n_in = 1'b0;
		req_in = 1'b0;
		rd_in = 1'b0;
		set_ptr_in = 1'b0;
		chip_in = 3'h0;
		addr_in = 7'h0;
		count_in = 2'h0;
		rd_len_in = 8'h1;
		r = $urandom(32'h5106);
		strap = r[2:0];
		wdata0_in = r[15:8];
		wdata1_in = r[23:16];
		repeat (5) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		xfer("foreign chip", 1'b0, 1'b1, strap ^ 3'h5, 7'h10, 2'h1, 8'h1, 1'b1);
		check("idle busy", {7'h0, s_busy}, 8'h0);
		// Start at the top location so the second byte wraps to zero.
		xfer("two byte write", 1'b0, 1'b1, strap, 7'h7F, 2'h2, 8'h1, 1'b0);
		for (n = 0; n < 1000 && s_busy !== 1'b1; n++) begin
			@(posedge ref_clk_in);
		end
		check("busy after stop", {7'h0, s_busy}, 8'h1);
		xfer("busy refusal", 1'b1, 1'b0, strap, 7'h0, 2'h0, 8'h1, 1'b1);
		for (n = 0; n < 100000 && s_busy !== 1'b0; n++) begin
			@(posedge ref_clk_in);
		end
		// Let the busy counter record the finished pair of intervals.
		repeat (2) @(posedge ref_clk_in);
		check("erase span", {7'h0, busy_len == 2 * EW_SIM}, 8'h1);
		exp_q.push_back(wdata0_in);
		exp_q.push_back(wdata1_in);
		xfer("pointer read", 1'b1, 1'b1, strap, 7'h7F, 2'h0, 8'h2, 1'b0);
		check("pointer", {1'b0, ptr}, 8'h00);
		exp_q.push_back(wdata1_in);
		xfer("direct read", 1'b1, 1'b0, strap, 7'h7F, 2'h0, 8'h1, 1'b0);
		check("pointer held", {1'b0, ptr}, 8'h00);
		check("notes left", 8'(exp_q.size()), 8'h00);
		finish_test();
	end
endmodule
